// ==== rtl/bmfs_params.svh ====
`ifndef BMFS_PARAMS_SVH
`define BMFS_PARAMS_SVH
`define BMFS_CLK_MHZ 100
`define BMFS_PRE_CHECK_US 200
`define BMFS_PRE_LIMIT_US 1000
`define BMFS_SS_LIMIT_US 128
`define BMFS_NOSW_US 5
`define BMFS_ILIM_LIMIT_US 150
`define BMFS_HICCUP_MS 22
`define BMFS_ILIM_PRE 2'h0
`define BMFS_ILIM_SS 2'h1
`define BMFS_ILIM_BOOST 2'h2
`define BMFS_ILIM_OFF 2'h3
`define BMFS_ONTIME_DEF 8'h04
`define BMFS_TMR_W 22
`endif

// ==== rtl/bmfs_pkg.sv ====
`default_nettype none
package bmfs_pkg;
  typedef enum logic [3:0] {
    BMFS_ST_PRECHARGE,
    BMFS_ST_SOFTSTART,
    BMFS_ST_BOOST,
    BMFS_ST_AUTOBYP,
    BMFS_ST_BYPASS,
    BMFS_ST_FAULT,
    BMFS_ST_THERMAL
  } bmfs_state_type;
  typedef enum logic [1:0] {
    BMFS_SW_IDLE,
    BMFS_SW_ON,
    BMFS_SW_OFF
  } bmfs_sw_type;
endpackage : bmfs_pkg
`default_nettype wire

// ==== rtl/bmfs_sequencer.sv ====
// Contract
// - Enable high boosts; enable low forces bypass (from reset or fault, the code stays in fault while enable is low).
// - Precharge 1.6A; after 200us need output above 1V.
// - Reach input minus 0.3V within 1ms.
// - Softstart switches with 1.5A limit.
// - No regulation after 128us softstart faults.
// - Softstart low output with overcurrent faults.
// - Successful startup enters normal boost.
// - Auto-bypass when input high, 5us no switching.
// - Leave auto-bypass below 0.98 target.
// - Auto-bypass low output faults.
// - Boost state valley limit 2.3A.
// - Current limit over 150us faults.
// - Valley overcurrent extends off-time.
// - Low-side on-time, then high-side, repeat.
// - Bypass keeps high-side switch fully on.
// - Bypass low output faults, disconnects path.
// - Undervoltage lockout forces fault state.
// - Fault stops switching, waits 22ms hiccup.
// - Thermal off above 150C, on below 130C.
`include "bmfs_params.svh"
`default_nettype none
module bmfs_sequencer #(
  parameter int CLK_MHZ = `BMFS_CLK_MHZ,
  parameter int PRE_CHECK_CYC = `BMFS_PRE_CHECK_US * CLK_MHZ,
  parameter int PRE_LIMIT_CYC = `BMFS_PRE_LIMIT_US * CLK_MHZ,
  parameter int SS_LIMIT_CYC = `BMFS_SS_LIMIT_US * CLK_MHZ,
  parameter int NOSW_CYC = `BMFS_NOSW_US * CLK_MHZ,
  parameter int ILIM_LIMIT_CYC = `BMFS_ILIM_LIMIT_US * CLK_MHZ,
  parameter int HICCUP_CYC = `BMFS_HICCUP_MS * 1000 * CLK_MHZ,
  parameter int TW = `BMFS_TMR_W
) (
  // Clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // Host enable pin.
  input wire logic I_EN,
  // Analog comparators from the power stage, and the on-time setting.
  input wire logic I_VOUT_GT_1V,
  input wire logic I_VOUT_GE_VIN_M03,
  input wire logic I_VOUT_IN_REG,
  input wire logic I_VIN_GT_NOM,
  input wire logic I_VIN_LT_098NOM,
  input wire logic I_VALLEY_OC,
  input wire logic I_UVLO,
  input wire logic I_TJ_HOT,
  input wire logic I_TJ_COOL,
  input wire logic [7:0] I_ON_TIME,
  // Power stage controls and status outputs.
  output logic O_LS_GATE,
  output logic O_HS_GATE,
  output logic O_PRECHARGE,
  output logic [1:0] O_ILIM_SEL,
  output logic O_FAULT,
  output logic O_THERMAL_OFF,
  output var bmfs_pkg::bmfs_state_type O_STATE
);
  import bmfs_pkg::*;

  localparam int NIN = 9;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync_in;
  logic [7:0] on_sync;
  logic en, vout_1v, vout_ok, vout_reg, vin_hi, vin_lo, oc, uvlo, tj_hot;
  logic tj_cool;
  bmfs_state_type state;
  bmfs_state_type next_state;
  bmfs_sw_type sw;
  logic [TW-1:0] tmr;
  logic [TW-1:0] oc_tmr;
  logic [TW-1:0] nosw_tmr;
  logic [7:0] sw_cnt;
  logic thermal;
  logic switching;

  assign raw_in = {I_EN, I_VOUT_GT_1V, I_VOUT_GE_VIN_M03, I_VOUT_IN_REG, I_VIN_GT_NOM,
                   I_VIN_LT_098NOM, I_VALLEY_OC, I_UVLO, I_TJ_HOT};

  bmfs_sync #(.WIDTH(NIN)) u_sync (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_async(raw_in),
    .o_sync(sync_in)
  );

  bmfs_sync #(.WIDTH(9)) u_sync_b (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_async({I_TJ_COOL, I_ON_TIME}),
    .o_sync({tj_cool, on_sync})
  );

  assign {en, vout_1v, vout_ok, vout_reg, vin_hi, vin_lo, oc, uvlo, tj_hot} = sync_in;
  assign switching = (state == BMFS_ST_SOFTSTART) || (state == BMFS_ST_BOOST);

  // Thermal shutdown latch with hysteresis between the two comparators.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      thermal <= 1'b0;
    end else if (tj_hot) begin
      thermal <= 1'b1;
    end else if (tj_cool) begin
      thermal <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      BMFS_ST_PRECHARGE: begin
        if (tmr >= TW'(PRE_CHECK_CYC) && !vout_1v) begin
          next_state = BMFS_ST_FAULT;
        end else if (vout_ok && tmr >= TW'(PRE_CHECK_CYC)) begin
          next_state = BMFS_ST_SOFTSTART;
        end else if (tmr >= TW'(PRE_LIMIT_CYC)) begin
          next_state = BMFS_ST_FAULT;
        end
      end
      BMFS_ST_SOFTSTART: begin
        if (!vout_ok && oc) begin
          next_state = BMFS_ST_FAULT;
        end else if (vout_reg) begin
          next_state = en ? BMFS_ST_BOOST : BMFS_ST_BYPASS;
        end else if (tmr > TW'(SS_LIMIT_CYC)) begin
          next_state = BMFS_ST_FAULT;
        end
      end
      BMFS_ST_BOOST: begin
        if (!en) begin
          next_state = BMFS_ST_BYPASS;
        end else if (oc_tmr > TW'(ILIM_LIMIT_CYC)) begin
          next_state = BMFS_ST_FAULT;
        end else if (vin_hi && nosw_tmr >= TW'(NOSW_CYC)) begin
          next_state = BMFS_ST_AUTOBYP;
        end
      end
      BMFS_ST_AUTOBYP: begin
        if (!en) begin
          next_state = BMFS_ST_BYPASS;
        end else if (!vout_ok) begin
          next_state = BMFS_ST_FAULT;
        end else if (vin_lo) begin
          next_state = BMFS_ST_BOOST;
        end
      end
      BMFS_ST_BYPASS: begin
        if (!vout_ok) begin
          next_state = BMFS_ST_FAULT;
        end else if (en) begin
          next_state = BMFS_ST_BOOST;
        end
      end
      BMFS_ST_FAULT: begin
        if (tmr >= TW'(HICCUP_CYC) && en && !uvlo) begin
          next_state = BMFS_ST_PRECHARGE;
        end
      end
      BMFS_ST_THERMAL: begin
        if (!thermal) begin
          next_state = BMFS_ST_FAULT;
        end
      end
      default: begin
        next_state = BMFS_ST_FAULT;
      end
    endcase
    if (state != BMFS_ST_THERMAL && state != BMFS_ST_FAULT && uvlo) begin
      next_state = BMFS_ST_FAULT;
    end
    if (thermal) begin
      next_state = BMFS_ST_THERMAL;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state <= BMFS_ST_FAULT;
    end else begin
      state <= next_state;
    end
  end

  // Phase timer restarts on every state entry.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      tmr <= '0;
    end else if (next_state != state) begin
      tmr <= '0;
    end else if (tmr != '1) begin
      tmr <= tmr + TW'(1);
    end
  end

  // Continuous current-limit duration in normal boost.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      oc_tmr <= '0;
    end else if (state != BMFS_ST_BOOST || !oc) begin
      oc_tmr <= '0;
    end else if (oc_tmr != '1) begin
      oc_tmr <= oc_tmr + TW'(1);
    end
  end

  // Time since the last low-side on-time ended.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      nosw_tmr <= '0;
    end else if (state != BMFS_ST_BOOST || (sw == BMFS_SW_ON)) begin
      nosw_tmr <= '0;
    end else if (nosw_tmr != '1) begin
      nosw_tmr <= nosw_tmr + TW'(1);
    end
  end

  // Constant on-time switching cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      sw <= BMFS_SW_IDLE;
      sw_cnt <= '0;
    end else if (!switching) begin
      sw <= BMFS_SW_IDLE;
      sw_cnt <= '0;
    end else begin
      case (sw)
        BMFS_SW_IDLE: begin
          sw <= BMFS_SW_ON;
          sw_cnt <= (on_sync == 8'h00) ? `BMFS_ONTIME_DEF : on_sync;
        end
        BMFS_SW_ON: begin
          if (sw_cnt <= 8'h01) begin
            sw <= BMFS_SW_OFF;
            sw_cnt <= `BMFS_ONTIME_DEF;
          end else begin
            sw_cnt <= sw_cnt - 8'h01;
          end
        end
        BMFS_SW_OFF: begin
          if (sw_cnt > 8'h01) begin
            sw_cnt <= sw_cnt - 8'h01;
          end else if (!oc && !vout_reg) begin
            // Cycles are skipped while in regulation, so light load stops switching.
            sw <= BMFS_SW_ON;
            sw_cnt <= (on_sync == 8'h00) ? `BMFS_ONTIME_DEF : on_sync;
          end
        end
        default: begin
          sw <= BMFS_SW_IDLE;
        end
      endcase
    end
  end

  // Registered power-stage outputs.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_LS_GATE <= 1'b0;
      O_HS_GATE <= 1'b0;
      O_PRECHARGE <= 1'b0;
      O_ILIM_SEL <= `BMFS_ILIM_OFF;
      O_FAULT <= 1'b1;
      O_THERMAL_OFF <= 1'b0;
      O_STATE <= BMFS_ST_FAULT;
    end else begin
      O_STATE <= state;
      O_FAULT <= (state == BMFS_ST_FAULT);
      O_THERMAL_OFF <= (state == BMFS_ST_THERMAL);
      O_PRECHARGE <= (state == BMFS_ST_PRECHARGE);
      O_LS_GATE <= switching && (sw == BMFS_SW_ON);
      O_HS_GATE <= (switching && sw == BMFS_SW_OFF) || (state == BMFS_ST_AUTOBYP) ||
                   (state == BMFS_ST_BYPASS);
      case (state)
        BMFS_ST_PRECHARGE: O_ILIM_SEL <= `BMFS_ILIM_PRE;
        BMFS_ST_SOFTSTART: O_ILIM_SEL <= `BMFS_ILIM_SS;
        BMFS_ST_BOOST: O_ILIM_SEL <= `BMFS_ILIM_BOOST;
        BMFS_ST_AUTOBYP: O_ILIM_SEL <= `BMFS_ILIM_BOOST;
        default: O_ILIM_SEL <= `BMFS_ILIM_OFF;
      endcase
    end
  end
endmodule : bmfs_sequencer
`default_nettype wire

// ==== rtl/bmfs_sync.sv ====
`default_nettype none
module bmfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : bmfs_sync
`default_nettype wire

// ==== tb/bmfs_monitor.sv ====
`default_nettype none
module bmfs_monitor #(
  parameter int HICCUP_CYC = 50
) (
  // Clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // Watched inputs.
  input wire logic I_UVLO,
  input wire logic I_TJ_HOT,
  // Watched outputs.
  input wire logic O_LS_GATE,
  input wire logic O_HS_GATE,
  input wire logic O_PRECHARGE,
  input wire logic [1:0] O_ILIM_SEL,
  input wire logic O_FAULT,
  input wire logic O_THERMAL_OFF,
  input wire bmfs_pkg::bmfs_state_type O_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmfs_pkg::*;
  int fcnt;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  // Length of the present fault stretch, so the hiccup wait can be measured.
  always_ff @(posedge I_REF_CLK) begin
    fcnt <= (I_SRST || !O_FAULT) ? 0 : fcnt + 1;
  end
  sequence hot_held;
    I_TJ_HOT [*6];
  endsequence
  sequence uv_held;
    (I_UVLO && !I_TJ_HOT && !O_THERMAL_OFF) [*6];
  endsequence
  sequence restart;
    $fell(O_FAULT) && !O_THERMAL_OFF;
  endsequence
  fault_quiet_a: assert property (O_FAULT |-> !O_LS_GATE && !O_HS_GATE)
    else $error("gate on in fault");
  hiccup_wait_a: assert property (restart |-> fcnt >= HICCUP_CYC)
    else $error("hiccup too short");
  restart_pre_a: assert property (restart |-> O_STATE == BMFS_ST_PRECHARGE)
    else $error("restart not into precharge");
  gate_excl_a: assert property (!(O_LS_GATE && O_HS_GATE))
    else $error("both gates on");
  bypass_hs_a: assert property (O_STATE == BMFS_ST_BYPASS |-> O_HS_GATE)
    else $error("bypass without high side");
  pre_ilim_a: assert property (O_PRECHARGE |-> O_ILIM_SEL == 2'h0 && !O_LS_GATE)
    else $error("precharge limit wrong");
  ss_ilim_a: assert property (O_STATE == BMFS_ST_SOFTSTART |-> O_ILIM_SEL == 2'h1)
    else $error("softstart limit wrong");
  boost_ilim_a: assert property (O_STATE == BMFS_ST_BOOST |-> O_ILIM_SEL == 2'h2)
    else $error("boost limit wrong");
  uvlo_fault_a: assert property (uv_held |-> O_FAULT)
    else $error("no fault in lockout");
  thermal_off_a: assert property (hot_held |-> O_THERMAL_OFF && !O_HS_GATE)
    else $error("stage on when hot");
endmodule : bmfs_monitor
bind bmfs_sequencer bmfs_monitor #(.HICCUP_CYC(HICCUP_CYC)) i_mon (.I_REF_CLK, .I_SRST,
  .I_UVLO, .I_TJ_HOT, .O_LS_GATE, .O_HS_GATE, .O_PRECHARGE, .O_ILIM_SEL, .O_FAULT,
  .O_THERMAL_OFF, .O_STATE);
`default_nettype wire

// ==== tb/bmfs_stage_model.sv ====
`default_nettype none
module bmfs_stage_model (
  // Clock.
  input wire logic i_clk,
  // Stage controls.
  input wire logic i_ls_gate,
  input wire logic i_precharge,
  input wire logic i_fault,
  input wire logic i_short,
  // Comparators.
  output logic o_vout_gt_1v,
  output logic o_vout_ge_vin,
  output logic o_vout_in_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  int charge = 0;
  // The linear charger alone stops short of regulation, so low-side pulses are needed.
  always @(posedge i_clk) begin
    if (i_short || i_fault)
      charge <= 0;
    else if (i_precharge && charge < 12)
      charge <= charge + 1;
    else if (i_ls_gate && charge < 63)
      charge <= charge + 1;
  end
  assign o_vout_gt_1v = charge > 4;
  assign o_vout_ge_vin = charge > 8;
  assign o_vout_in_reg = charge > 16;
endmodule : bmfs_stage_model
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bmfs_pkg::*;
  logic clk = 1'b0, srst = 1'b1, en = 1'b1, vnom = 1'b0, vlo = 1'b0, oc = 1'b0;
  logic [7:0] on_time = 8'h03;
  logic uvlo = 1'b0, hot = 1'b0, cool = 1'b1, dead = 1'b0;
  logic ls, hs, pre, flt, thoff, v1, vok, vreg;
  logic [1:0] ilim;
  bmfs_state_type st;
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  bmfs_sequencer #(.PRE_CHECK_CYC(20), .PRE_LIMIT_CYC(100), .SS_LIMIT_CYC(40),
    .NOSW_CYC(10), .ILIM_LIMIT_CYC(30), .HICCUP_CYC(50)) i_dut (.I_REF_CLK(clk),
    .I_SRST(srst), .I_EN(en), .I_VOUT_GT_1V(v1), .I_VOUT_GE_VIN_M03(vok),
    .I_VOUT_IN_REG(vreg), .I_VIN_GT_NOM(vnom), .I_VIN_LT_098NOM(vlo), .I_VALLEY_OC(oc),
    .I_UVLO(uvlo), .I_TJ_HOT(hot), .I_TJ_COOL(cool), .I_ON_TIME(on_time), .O_LS_GATE(ls),
    .O_HS_GATE(hs), .O_PRECHARGE(pre), .O_ILIM_SEL(ilim), .O_FAULT(flt),
    .O_THERMAL_OFF(thoff), .O_STATE(st));
  bmfs_stage_model i_stage (.i_clk(clk), .i_ls_gate(ls), .i_precharge(pre),
    .i_fault(flt), .i_short(dead), .o_vout_gt_1v(v1), .o_vout_ge_vin(vok),
    .o_vout_in_reg(vreg));
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wait_st(input bmfs_state_type exp, input int lim);
    int k;
    k = 0;
    while (st !== exp && k < lim) begin
      tick(1);
      k++;
    end
    chk(st === exp, 1'b1, "state not reached");
    if (st !== exp)
      conclude();
  endtask : wait_st
  task automatic t_start;
    wait_st(BMFS_ST_PRECHARGE, 80);
    chk(ilim === 2'h0, 1'b1, "precharge limit");
    wait_st(BMFS_ST_SOFTSTART, 40);
    chk(ilim === 2'h1, 1'b1, "softstart limit");
    wait_st(BMFS_ST_BOOST, 60);
    chk(ilim === 2'h2, 1'b1, "boost limit");
    $display("start done");
  endtask : t_start
  task automatic t_bypass;
    en = 1'b0;
    wait_st(BMFS_ST_BYPASS, 10);
    chk(hs & ~ls, 1'b1, "bypass gates");
    en = 1'b1;
    wait_st(BMFS_ST_BOOST, 10);
    $display("bypass done");
  endtask : t_bypass
  task automatic t_autobyp;
    vnom = 1'b1;
    wait_st(BMFS_ST_AUTOBYP, 300);
    vnom = 1'b0;
    vlo = 1'b1;
    wait_st(BMFS_ST_BOOST, 10);
    vlo = 1'b0;
    $display("autobypass done");
  endtask : t_autobyp
  task automatic t_limit;
    oc = 1'b1;
    tick(12);
    chk(ls, 1'b0, "on-time during limit");
    tick(18);
    chk(flt, 1'b0, "early limit fault");
    wait_st(BMFS_ST_FAULT, 20);
    oc = 1'b0;
    tick(45);
    chk(st === BMFS_ST_FAULT, 1'b1, "hiccup short");
    t_start();
    $display("limit done");
  endtask : t_limit
  task automatic t_droop;
    en = 1'b0;
    wait_st(BMFS_ST_BYPASS, 10);
    dead = 1'b1;
    wait_st(BMFS_ST_FAULT, 10);
    chk(hs, 1'b0, "path not opened");
    en = 1'b1;
    wait_st(BMFS_ST_PRECHARGE, 80);
    wait_st(BMFS_ST_FAULT, 30);
    dead = 1'b0;
    on_time = 8'h00;
    t_start();
    on_time = 8'h03;
    $display("droop done");
  endtask : t_droop
  task automatic t_uvlo;
    en = 1'b0;
    uvlo = 1'b1;
    wait_st(BMFS_ST_FAULT, 10);
    uvlo = 1'b0;
    tick(80);
    chk(st === BMFS_ST_FAULT, 1'b1, "restart with enable low");
    en = 1'b1;
    t_start();
    $display("uvlo done");
  endtask : t_uvlo
  task automatic t_thermal;
    hot = 1'b1;
    cool = 1'b0;
    tick(6);
    chk(thoff & ~hs & ~ls, 1'b1, "thermal off");
    hot = 1'b0;
    tick(10);
    chk(thoff, 1'b1, "hysteresis");
    cool = 1'b1;
    wait_st(BMFS_ST_FAULT, 10);
    t_start();
    $display("thermal done");
  endtask : t_thermal
  initial begin
    tick(6);
    srst = 1'b0;
    t_start();
    t_bypass();
    t_autobyp();
    t_limit();
    t_droop();
    t_uvlo();
    t_thermal();
    conclude();
  end
endmodule : testbench
`default_nettype wire
